// File: design/ebac_pkg.sv
// package: constants shared by both ends of the byte access block
// Notes on behaviour
// - 512 bytes, each byte read/written alone
// - read strobe stalls processor four cycles
// - write strobe stalls processor two cycles
// - strobe within four cycles of arm
// - arm writes one arm, zero strobe
// - wait strobe clear before arming write
// - no write during self-programming busy
// - keep interrupts off through write sequence
// - hardware clears strobe when write done
// - during write ignore reads, freeze address
// - poll strobe clear before read strobe
// - write timed by RC oscillator ticks
// - write lasts 27072 oscillator cycles
// - write completes through power-down sleep
// - confirm write done before power-down
// - reset does not abort running write
// - registers reachable in processor register space
// - read data available right after strobe
// - arm bit self-clears after four cycles
// - strobe without arm does nothing
// - ready interrupt level while strobe clear
package ebac_pkg;
   localparam int unsigned MEM_BYTES   = 512;
   localparam int unsigned ADDR_W      = 9;
   localparam int unsigned READ_STALL  = 4;
   localparam int unsigned WRITE_STALL = 2;
   localparam int unsigned ARM_WINDOW  = 4;
   localparam int unsigned WRITE_OSC   = 27072;
   // register indices inside the device space
   localparam logic [1:0] IDX_ADDR_LO = 2'h0;
   localparam logic [1:0] IDX_ADDR_HI = 2'h1;
   localparam logic [1:0] IDX_DATA    = 2'h2;
   localparam logic [1:0] IDX_CTRL    = 2'h3;
   // control register bits
   localparam int unsigned BIT_READ   = 0;
   localparam int unsigned BIT_WRITE  = 1;
   localparam int unsigned BIT_ARM    = 2;
   localparam int unsigned BIT_RDYIE  = 3;
   // controller (wishbone slave) offsets, byte addresses
   localparam logic [3:0] WB_CMD      = 4'h0;
   localparam logic [3:0] WB_ADDR     = 4'h4;
   localparam logic [3:0] WB_WDATA    = 4'h8;
   localparam logic [3:0] WB_STATUS   = 4'hC;
   // command codes in WB_CMD
   localparam logic [1:0] CMD_READ    = 2'h1;
   localparam logic [1:0] CMD_WRITE   = 2'h2;
   localparam logic [1:0] CMD_RDYIE   = 2'h3;
   // oscillator tick divider: one tick per this many core cycles
   localparam logic [3:0] OSC_DIV     = 4'h3;
endpackage

// File: design/ebac_if.sv
// interface: processor register port between controller and device
`timescale 1ns/10ps
interface ebac_if;
   logic       we;
   logic       re;
   logic [1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       stall;
   logic       irq;
   modport dev (input we, re, idx, wdata, output rdata, stall, irq);
   modport ctl (output we, re, idx, wdata, input rdata, stall, irq);
endinterface

// File: design/ebac_device.sv
// device end: byte store with arm/strobe write protection and stall
`timescale 1ns/10ps
module ebac_device (
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   // system conditions
   input  wire logic            osc_tick_i,
   input  wire logic            selfprog_busy_bit_i,
   input  wire logic            sleep_i,
   // processor register port
   ebac_if.dev                  bus,
   // status
   output logic                 writing_o,
   output logic                 osc_run_o
);
   typedef enum logic [0:0] {EBAC_IDLE, EBAC_WRITE} ebac_state_t;

   logic [7:0]                 mem [0:ebac_pkg::MEM_BYTES-1];
   ebac_state_t                st_reg, st_next;
   logic [ebac_pkg::ADDR_W-1:0] byte_address_reg, addr_next;
   logic [7:0]                 byte_data_reg, data_next;
   logic [ebac_pkg::ADDR_W-1:0] wr_addr_reg, wr_addr_next;
   logic [7:0]                 wr_data_reg, wr_data_next;
   logic                       write_arm_bit_reg, arm_next;
   logic [2:0]                 arm_cnt_reg, arm_cnt_next;
   logic                       ready_irq_enable_reg, rdyie_next;
   logic [14:0]                osc_cnt_reg, osc_cnt_next;
   logic [2:0]                 stall_cnt_reg, stall_cnt_next;
   logic [7:0]                 rdata_reg, rdata_next;
   logic                       irq_reg, irq_next;
   logic                       mem_we;

   // next state of all control; reset only clears what a write can survive
   always_comb begin
      st_next        = st_reg;
      addr_next      = byte_address_reg;
      data_next      = byte_data_reg;
      wr_addr_next   = wr_addr_reg;
      wr_data_next   = wr_data_reg;
      arm_next       = write_arm_bit_reg;
      arm_cnt_next   = arm_cnt_reg;
      rdyie_next     = ready_irq_enable_reg;
      osc_cnt_next   = osc_cnt_reg;
      stall_cnt_next = (stall_cnt_reg != 3'h0) ? stall_cnt_reg - 3'h1 : 3'h0;
      mem_we         = 1'b0;
      // arm window countdown
      if (write_arm_bit_reg) begin
         if (arm_cnt_reg == 3'h1)
            arm_next = 1'b0;
         arm_cnt_next = arm_cnt_reg - 3'h1;
      end
      // self-timed write, counted only on oscillator ticks
      if (st_reg == EBAC_WRITE && osc_tick_i) begin
         if (osc_cnt_reg == 15'(ebac_pkg::WRITE_OSC - 1)) begin
            mem_we  = 1'b1;
            st_next = EBAC_IDLE;
         end
         osc_cnt_next = osc_cnt_reg + 15'h1;
      end
      if (bus.we) begin
         unique case (bus.idx)
            ebac_pkg::IDX_ADDR_LO:
               if (st_reg == EBAC_IDLE)
                  addr_next = {byte_address_reg[8], bus.wdata};
            ebac_pkg::IDX_ADDR_HI:
               if (st_reg == EBAC_IDLE)
                  addr_next = {bus.wdata[0], byte_address_reg[7:0]};
            ebac_pkg::IDX_DATA:
               data_next = bus.wdata;
            ebac_pkg::IDX_CTRL: begin
               rdyie_next = bus.wdata[ebac_pkg::BIT_RDYIE];
               if (bus.wdata[ebac_pkg::BIT_ARM] &&
                   !bus.wdata[ebac_pkg::BIT_WRITE]) begin
                  arm_next     = 1'b1;
                  arm_cnt_next = 3'(ebac_pkg::ARM_WINDOW);
               end else if (bus.wdata[ebac_pkg::BIT_WRITE] &&
                            write_arm_bit_reg &&
                            st_reg == EBAC_IDLE &&
                            !selfprog_busy_bit_i) begin
                  st_next        = EBAC_WRITE;
                  wr_addr_next   = byte_address_reg;
                  wr_data_next   = byte_data_reg;
                  osc_cnt_next   = 15'h0;
                  arm_next       = 1'b0;
                  stall_cnt_next = 3'(ebac_pkg::WRITE_STALL);
               end else if (bus.wdata[ebac_pkg::BIT_READ] &&
                            st_reg == EBAC_IDLE) begin
                  data_next      = mem[byte_address_reg];
                  stall_cnt_next = 3'(ebac_pkg::READ_STALL);
               end
            end
         endcase
      end
      rdata_next = 8'h00;
      if (bus.re) begin
         unique case (bus.idx)
            ebac_pkg::IDX_ADDR_LO: rdata_next = byte_address_reg[7:0];
            ebac_pkg::IDX_ADDR_HI: rdata_next = {7'h00, byte_address_reg[8]};
            ebac_pkg::IDX_DATA:    rdata_next = data_next;
            ebac_pkg::IDX_CTRL:    rdata_next =
               {4'h0, ready_irq_enable_reg, write_arm_bit_reg,
                st_reg == EBAC_WRITE, 1'b0};
         endcase
      end
      irq_next = rdyie_next && st_next == EBAC_IDLE;
      // reset clears registers but lets a running write finish
      if (!rst_n_i) begin
         addr_next      = '0;
         data_next      = 8'h00;
         arm_next       = 1'b0;
         arm_cnt_next   = 3'h0;
         rdyie_next     = 1'b0;
         stall_cnt_next = 3'h0;
         rdata_next     = 8'h00;
         irq_next       = 1'b0;
      end
   end

   // state registers; the write engine ignores reset once running
   always_ff @(posedge clk_i) begin
      byte_address_reg     <= addr_next;
      byte_data_reg        <= data_next;
      write_arm_bit_reg    <= arm_next;
      arm_cnt_reg          <= arm_cnt_next;
      ready_irq_enable_reg <= rdyie_next;
      stall_cnt_reg        <= stall_cnt_next;
      rdata_reg            <= rdata_next;
      irq_reg              <= irq_next;
      wr_addr_reg          <= wr_addr_next;
      wr_data_reg          <= wr_data_next;
      osc_cnt_reg          <= osc_cnt_next;
      // an unknown power-up state must also fall to idle under reset
      if (rst_n_i || st_reg == EBAC_WRITE)
         st_reg <= st_next;
      else
         st_reg <= EBAC_IDLE;
      if (mem_we)
         mem[wr_addr_reg] <= wr_data_reg;
      writing_o <= (st_next == EBAC_WRITE);
      osc_run_o <= (st_next == EBAC_WRITE) || sleep_i == 1'b0;
   end

   // rdata and irq straight from flops, stall decoded from the stall counter
   assign bus.rdata = rdata_reg;
   assign bus.stall = (stall_cnt_reg != 3'h0);
   assign bus.irq   = irq_reg;
endmodule // ebac_device

// File: design/ebac_ctrl.sv
// controller end: wishbone slave that runs the register sequences
`timescale 1ns/10ps
module ebac_ctrl (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // system
   input  wire logic        selfprog_busy_bit_i,
   // device port
   ebac_if.ctl              dev
);
   typedef enum logic [2:0] {
      EBC_IDLE, EBC_POLL, EBC_POLLW, EBC_SETA, EBC_SETAH, EBC_SETD,
      EBC_ARM, EBC_GO
   } ebc_state_t;

   ebc_state_t   st_reg, st_next;
   logic [1:0]   cmd_reg, cmd_next;
   logic [8:0]   addr_reg, addr_next;
   logic [7:0]   wdat_reg, wdat_next, rdat_reg, rdat_next;
   logic         busy_reg, busy_next, ack_reg, ack_next;
   logic         rdyie_reg, rdyie_next;
   logic         we_reg, we_next, re_reg, re_next;
   logic [1:0]   idx_reg, idx_next;
   logic [7:0]   bd_reg, bd_next;
   logic [31:0]  dat_reg, dat_next;

   // command sequencer and bus slave
   always_comb begin
      st_next = st_reg; cmd_next = cmd_reg; addr_next = addr_reg;
      wdat_next = wdat_reg; rdat_next = rdat_reg; busy_next = busy_reg;
      rdyie_next = rdyie_reg; we_next = 1'b0; re_next = 1'b0;
      idx_next = idx_reg; bd_next = bd_reg; dat_next = dat_reg;
      ack_next = 1'b0;
      if (wb_cyc_i && wb_stb_i && !ack_reg) begin
         ack_next = 1'b1;
         dat_next = 32'h0000_0000;
         if (wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
               ebac_pkg::WB_ADDR:  if (!busy_reg) addr_next = wb_dat_i[8:0];
               ebac_pkg::WB_WDATA: if (!busy_reg) wdat_next = wb_dat_i[7:0];
               ebac_pkg::WB_CMD:
                  if (!busy_reg && wb_dat_i[1:0] != 2'h0) begin
                     cmd_next = wb_dat_i[1:0];
                     if (wb_dat_i[1:0] == ebac_pkg::CMD_RDYIE)
                        rdyie_next = wb_dat_i[2];
                     busy_next = 1'b1;
                     st_next = EBC_POLL;
                  end
               default: ;
            endcase
         end else if (!wb_we_i) begin
            unique case (wb_adr_i)
               ebac_pkg::WB_ADDR:   dat_next = {23'h0, addr_reg};
               ebac_pkg::WB_WDATA:  dat_next = {24'h0, wdat_reg};
               ebac_pkg::WB_STATUS: dat_next = {21'h0, dev.irq, rdyie_reg,
                                                busy_reg, rdat_reg};
               default:             dat_next = 32'h0000_0000;
            endcase
         end
      end
      unique case (st_reg)
         EBC_IDLE: ;
         EBC_POLL: begin   // read control register
            if (!dev.stall) begin
               re_next = 1'b1; idx_next = ebac_pkg::IDX_CTRL;
               st_next = EBC_POLLW;
            end
         end
         EBC_POLLW: begin  // strobe clear before any access, self-prog clear before a write
            if (!re_reg) begin
               if (dev.rdata[ebac_pkg::BIT_WRITE] ||
                   (cmd_reg == ebac_pkg::CMD_WRITE &&
                    selfprog_busy_bit_i))
                  st_next = EBC_POLL;
               else if (cmd_reg == ebac_pkg::CMD_RDYIE) begin
                  we_next = 1'b1; idx_next = ebac_pkg::IDX_CTRL;
                  bd_next = {4'h0, rdyie_reg, 3'h0};
                  st_next = EBC_GO;
               end else
                  st_next = EBC_SETA;
            end
         end
         EBC_SETA: begin
            we_next = 1'b1; idx_next = ebac_pkg::IDX_ADDR_LO;
            bd_next = addr_reg[7:0]; st_next = EBC_SETAH;
         end
         EBC_SETAH: begin
            we_next = 1'b1; idx_next = ebac_pkg::IDX_ADDR_HI;
            bd_next = {7'h00, addr_reg[8]};
            st_next = (cmd_reg == ebac_pkg::CMD_WRITE) ? EBC_SETD : EBC_ARM;
         end
         EBC_SETD: begin
            we_next = 1'b1; idx_next = ebac_pkg::IDX_DATA;
            bd_next = wdat_reg; st_next = EBC_ARM;
         end
         EBC_ARM: begin    // write: arm then strobe back to back, no gap; read: read strobe alone
            we_next = 1'b1; idx_next = ebac_pkg::IDX_CTRL;
            if (cmd_reg == ebac_pkg::CMD_WRITE)
               bd_next = {4'h0, rdyie_reg, 3'b100};
            else
               bd_next = {4'h0, rdyie_reg, 3'b001};
            st_next = EBC_GO;
            if (cmd_reg == ebac_pkg::CMD_WRITE && we_reg &&
                idx_reg == ebac_pkg::IDX_CTRL)
               bd_next = {4'h0, rdyie_reg, 3'b010};
         end
         EBC_GO: begin
            if (cmd_reg == ebac_pkg::CMD_WRITE && bd_reg[2]) begin
               we_next = 1'b1;
               bd_next = {4'h0, rdyie_reg, 3'b010};
            end else if (!dev.stall && !we_reg) begin
               if (cmd_reg == ebac_pkg::CMD_READ && !re_reg) begin
                  re_next = 1'b1; idx_next = ebac_pkg::IDX_DATA;
                  cmd_next = 2'h0;
               end else if (!re_reg) begin
                  if (cmd_reg == 2'h0) rdat_next = dev.rdata;
                  busy_next = 1'b0; st_next = EBC_IDLE;
               end
            end
         end
      endcase
      if (!rst_n_i) begin
         st_next = EBC_IDLE; cmd_next = 2'h0; addr_next = 9'h000;
         wdat_next = 8'h00; rdat_next = 8'h00; busy_next = 1'b0;
         rdyie_next = 1'b0; we_next = 1'b0; re_next = 1'b0;
         idx_next = 2'h0; bd_next = 8'h00; dat_next = 32'h0000_0000;
         ack_next = 1'b0;
      end
   end

   // register everything
   always_ff @(posedge clk_i) begin
      st_reg <= st_next; cmd_reg <= cmd_next; addr_reg <= addr_next;
      wdat_reg <= wdat_next; rdat_reg <= rdat_next; busy_reg <= busy_next;
      rdyie_reg <= rdyie_next; we_reg <= we_next; re_reg <= re_next;
      idx_reg <= idx_next; bd_reg <= bd_next; dat_reg <= dat_next;
      ack_reg <= ack_next;
   end

   assign wb_dat_o  = dat_reg;
   assign wb_ack_o  = ack_reg;
   assign dev.we    = we_reg;
   assign dev.re    = re_reg;
   assign dev.idx   = idx_reg;
   assign dev.wdata = bd_reg;
endmodule // ebac_ctrl

// File: tb/ebac_chk_sva.sv
// checker: timing relations on the device port and the wishbone side
`timescale 1ns/10ps
module ebac_chk (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // device port
   input  wire logic       we,
   input  wire logic [1:0] idx,
   input  wire logic [7:0] wdata,
   input  wire logic       stall,
   input  wire logic       irq,
   // device status and system
   input  wire logic       writing_o,
   input  wire logic       osc_run_o,
   input  wire logic       sleep_i,
   // wishbone
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_ack_o
);
   // one cycle of slack: the write flag is registered after the strobe
   localparam int ARM_MAX = 5;
   logic       ctl_wr;
   logic [3:0] arm_age;
   logic [3:0] stall_len;
   logic       rd_kind;
   logic       ie_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   assign ctl_wr = we && idx == ebac_pkg::IDX_CTRL;

   // age of the last arm, length of the last stall, last strobe kind
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         arm_age   <= 4'hF;
         stall_len <= 4'h0;
         rd_kind   <= 1'b0;
         ie_q      <= 1'b0;
      end else begin
         if (ctl_wr && wdata[ebac_pkg::BIT_ARM]) begin
            arm_age <= 4'h0;
         end else if (arm_age != 4'hF) begin
            arm_age <= arm_age + 4'h1;
         end
         stall_len <= $rose(stall) ? 4'h1 : stall ? stall_len + 4'h1
                                                 : stall_len;
         if (ctl_wr && wdata[ebac_pkg::BIT_READ]) begin
            rd_kind <= 1'b1;
         end else if (ctl_wr && wdata[ebac_pkg::BIT_WRITE]) begin
            rd_kind <= 1'b0;
         end
         if (ctl_wr) begin
            ie_q <= wdata[ebac_pkg::BIT_RDYIE];
         end
      end
   end

   sequence arm_s;
      ctl_wr && wdata[ebac_pkg::BIT_ARM];
   endsequence
   sequence strobe_s;
      ctl_wr && wdata[ebac_pkg::BIT_WRITE];
   endsequence

   arm_form_a: assert property (arm_s |-> !wdata[ebac_pkg::BIT_WRITE])
      else $error("arm written together with strobe");
   strobe_window_a: assert property (arm_s |-> ##[1:4] strobe_s)
      else $error("strobe missed the arm window");
   write_start_a: assert property ($rose(writing_o) |-> arm_age <= ARM_MAX)
      else $error("write started without a recent arm");
   write_stall_a: assert property ($fell(stall) && !rd_kind |->
      stall_len == ebac_pkg::WRITE_STALL) else $error("bad write stall");
   read_stall_a: assert property ($fell(stall) && rd_kind |->
      stall_len == ebac_pkg::READ_STALL) else $error("bad read stall");
   irq_on_a: assert property ((ie_q && !writing_o)[*2] |-> irq)
      else $error("ready interrupt missing");
   irq_off_a: assert property ((!ie_q || writing_o)[*2] |-> !irq)
      else $error("ready interrupt while not ready");
   sleep_hold_a: assert property (sleep_i && writing_o |-> osc_run_o)
      else $error("timing clock stopped during write");
   sleep_stop_a: assert property ((sleep_i && !writing_o)[*2] |-> !osc_run_o)
      else $error("timing clock runs in sleep");
   reset_keep_a: assert property ($rose(rst_n_i) && $past(writing_o, 2)
      |-> writing_o) else $error("reset aborted the write");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule // ebac_chk

// File: tb/ebac_bench.sv
// bench: both ends joined, wishbone stimulus and self checks
`timescale 1ns/10ps
module ebac_bench;
   typedef struct {
      logic        we;
      logic [3:0]  adr;
      logic [31:0] dat;
      logic [31:0] msk;
      logic [31:0] exp;
   } ebac_row_t;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        selfprog_busy_bit_i = 1'b0;
   logic        sleep_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        writing_o;
   logic        osc_run_o;
   logic [31:0] rd;
   int          bad_count = 0;
   int          total_checks = 0;
   int          n;
   int          run = 0;
   int          last_len = 0;
   ebac_row_t   rows [6];
   ebac_if      link ();

   // tick every cycle so one write lasts WRITE_OSC clocks
   ebac_device ebac_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .osc_tick_i(1'b1), .selfprog_busy_bit_i(selfprog_busy_bit_i),
      .sleep_i(sleep_i), .bus(link.dev), .writing_o(writing_o),
      .osc_run_o(osc_run_o));
   ebac_ctrl ebac_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .selfprog_busy_bit_i(selfprog_busy_bit_i), .dev(link.ctl));
   ebac_chk ebac_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .we(link.we),
      .idx(link.idx), .wdata(link.wdata), .stall(link.stall),
      .irq(link.irq), .writing_o(writing_o), .osc_run_o(osc_run_o),
      .sleep_i(sleep_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o));

   always #25 clk_i = ~clk_i;

   // length of the last finished write, reset cannot stop it
   always @(posedge clk_i) begin
      if (writing_o === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         last_len <= run;
         run <= 0;
      end
   end

   // one classic cycle; the request stands until ack is sampled
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (wb_ack_o !== 1'b1) begin
         $display("Error ack expected 1 seen %b", wb_ack_o);
         bad_count++;
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask

   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask

   // poll the busy flag; a limit keeps a stuck design from hanging
   task automatic wait_idle(input int lim);
      int k;
      k = 0;
      do begin
         xfer(1'b0, ebac_pkg::WB_STATUS, 32'h0000_0000);
         k++;
      end while (rd[8] !== 1'b0 && k < lim);
      if (rd[8] !== 1'b0) begin
         $display("Error busy expected 0 seen %b", rd[8]);
         bad_count++;
      end
   endtask

   // the sequencer drops busy before the byte is stored, so watch the end
   task automatic wait_write(input int lim);
      int k;
      k = 0;
      while (writing_o !== 1'b0 && k < lim) begin
         @(posedge clk_i);
         k++;
      end
      if (writing_o !== 1'b0) begin
         $display("Error writing expected 0 seen %b", writing_o);
         bad_count++;
      end
   endtask

   task automatic put(input logic [8:0] a, input logic [7:0] d,
                      input logic [1:0] c);
      xfer(1'b1, ebac_pkg::WB_ADDR, {23'h00_0000, a});
      xfer(1'b1, ebac_pkg::WB_WDATA, {24'h00_0000, d});
      xfer(1'b1, ebac_pkg::WB_CMD, {30'h0000_0000, c});
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // two full writes at one tick a clock, plus margin
   initial begin
      repeat (100000) @(posedge clk_i);
      bad_count++;
      close_out();
   end

   initial begin
      rows = '{
         '{1'b1, ebac_pkg::WB_CMD, 32'h0000_0007, 32'h0, 32'h0},
         '{1'b0, ebac_pkg::WB_STATUS, 32'h0, 32'h0000_0700, 32'h0000_0600},
         '{1'b1, ebac_pkg::WB_CMD, 32'h0000_0003, 32'h0, 32'h0},
         '{1'b0, ebac_pkg::WB_STATUS, 32'h0, 32'h0000_0700, 32'h0},
         '{1'b0, 4'h2, 32'h0, 32'hFFFF_FFFF, 32'h0},
         '{1'b0, 4'hE, 32'h0, 32'hFFFF_FFFF, 32'h0}};
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      check("ack", 1'b0, wb_ack_o);
      check("stall", 1'b0, link.stall);
      $display("test reset done");
      foreach (rows[i]) begin
         xfer(rows[i].we, rows[i].adr, rows[i].dat);
         if (rows[i].we) begin
            wait_idle(50);
         end else begin
            check("row", rows[i].exp, rd & rows[i].msk);
         end
      end
      $display("test rows done");
      // top address, refused address change, sleep and reset mid-write
      put(9'h1FF, 8'hA5, ebac_pkg::CMD_WRITE);
      n = 0;
      while (writing_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      check("write started", 1'b1, writing_o);
      wait_idle(50);
      // a read queued behind the write keeps the sequencer busy
      xfer(1'b1, ebac_pkg::WB_CMD, 32'h0000_0001);
      xfer(1'b1, ebac_pkg::WB_ADDR, 32'h0000_0000);
      xfer(1'b0, ebac_pkg::WB_ADDR, 32'h0000_0000);
      check("addr kept", 32'h0000_01FF, rd);
      xfer(1'b0, ebac_pkg::WB_STATUS, 32'h0000_0000);
      check("busy in write", 1'b1, rd[8]);
      sleep_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      check("clock in sleep", 1'b1, osc_run_o);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      check("write in reset", 1'b1, writing_o);
      wait_write(30000);
      repeat (2) @(posedge clk_i);
      check("length ok", 1'b1, last_len >= ebac_pkg::WRITE_OSC &&
            last_len <= ebac_pkg::WRITE_OSC + 2);
      check("clock stopped", 1'b0, osc_run_o);
      sleep_i <= 1'b0;
      xfer(1'b1, ebac_pkg::WB_CMD, 32'h0000_0007);
      wait_idle(50);
      put(9'h1FF, 8'h00, ebac_pkg::CMD_READ);
      wait_idle(50);
      check("status", 11'h6A5, rd[10:0]);
      $display("test write done");
      // blocked while self-programming runs, then a second byte
      selfprog_busy_bit_i <= 1'b1;
      put(9'h000, 8'h3C, ebac_pkg::CMD_WRITE);
      repeat (20) @(posedge clk_i);
      check("blocked", 1'b0, writing_o);
      selfprog_busy_bit_i <= 1'b0;
      wait_idle(50);
      // the read waits in the sequencer until the byte is stored
      put(9'h000, 8'h00, ebac_pkg::CMD_READ);
      wait_idle(20000);
      check("low byte", 8'h3C, rd[7:0]);
      put(9'h1FF, 8'h00, ebac_pkg::CMD_READ);
      wait_idle(50);
      check("top byte", 8'hA5, rd[7:0]);
      $display("test selfprog done");
      close_out();
   end
endmodule // ebac_bench
